// ### design/lds_pkg.sv
/*
  lds_pkg: constants and carrier types for the led driver two-wire slave port.
  assumes a 200 MHz system clock; serial pins are synchronised inside the port.
*/
package lds_pkg;

  // ************************************************************
  // bus address
  // ************************************************************
  localparam logic [4:0] LDS_ADDR_FIXED   = 5'h1D;  // binary 11101
  localparam logic [1:0] LDS_SEL_GND      = 2'h0;
  localparam logic [1:0] LDS_SEL_SCL      = 2'h1;
  localparam logic [1:0] LDS_SEL_SDA      = 2'h2;
  localparam logic [1:0] LDS_SEL_VCC      = 2'h3;
  localparam logic       LDS_DIR_WRITE    = 1'b0;
  localparam logic       LDS_DIR_READ     = 1'b1;

  // ************************************************************
  // timing and reset values
  // ************************************************************
  localparam int         LDS_CLK_MHZ      = 200;
  localparam int         LDS_SCL_MAX_KHZ  = 400;
  localparam int         LDS_SCL_MIN_CYC  = (LDS_CLK_MHZ * 1000) / LDS_SCL_MAX_KHZ;
  localparam logic [7:0] LDS_PTR_RST      = 8'h00;
  localparam logic [2:0] LDS_BIT_LAST     = 3'h7;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum {LDS_IDLE, LDS_ADDR, LDS_ADDR_ACK, LDS_PTR, LDS_PTR_ACK,
                LDS_WDATA, LDS_WDATA_ACK, LDS_RDATA, LDS_RDATA_ACK, LDS_IGNORE} lds_state_t;

  // register-space access toward the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lds_req_t;

  // open-drain data pin toward the pad
  typedef struct packed {
    logic o;
    logic oe;
  } lds_pin_t;

endpackage : lds_pkg

// ### design/lds_slave.sv
/*
  lds_slave: two-wire serial slave port in front of the led driver register space.
  assumes scl, sda and the address-select level arrive asynchronously and the core
  answers a read strobe with rdata on the next clock.
*/
// Function
// - answer only address 11101 followed by two select bits
// - eighth address bit: 0 writes, 1 reads
// - select pin decode: gnd 00, vcc 11, scl 01, sda 10
// - sample sda at scl rise; change only while scl low
// - start is sda fall with scl high; begins address compare
// - pull sda low on ack pulse after matching address
// - pointer byte follows write address and is acknowledged
// - data bytes msb first, acknowledged, stored at pointer
// - stop is sda rise with scl high; back to idle
// - pointer advances by one during each write data ack
// - read: write pointer, repeated start, read address, data returned
`timescale 1ns/10ps
module lds_slave
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // serial pins
  input  wire logic          scl_i,
  input  wire logic          sda_i,
  output lds_pkg::lds_pin_t  sda_pin,
  // address-select pin, already classified into where it connects
  input  wire logic [1:0]    sel_conn_i,
  // register space
  output lds_pkg::lds_req_t  req,
  input  wire logic [7:0]    rdata_i
);
  import lds_pkg::*;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [1:0] scl_s_r, sda_s_r;
  logic [1:0] sel_a_r, sel_b_r;
  logic       scl_d_r, sda_d_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      sel_a_r <= 2'h0;
      sel_b_r <= 2'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      sel_a_r <= sel_conn_i;
      sel_b_r <= sel_a_r;
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
  assign scl      = scl_s_r[1];
  assign sda      = sda_s_r[1];
  assign scl_rise = scl & ~scl_d_r;
  assign scl_fall = ~scl & scl_d_r;
  assign start_ev = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_ev  = scl & scl_d_r & ~sda_d_r & sda;

  // ************************************************************
  // own address
  // ************************************************************
  logic [1:0] low_bits;
  always_comb begin
    case (sel_b_r)
      LDS_SEL_GND: low_bits = 2'h0;
      LDS_SEL_VCC: low_bits = 2'h3;
      LDS_SEL_SCL: low_bits = 2'h1;
      LDS_SEL_SDA: low_bits = 2'h2;
      default:     low_bits = 2'h0;
    endcase
  end
  logic [6:0] device_bus_address_bits;
  assign device_bus_address_bits = {LDS_ADDR_FIXED, low_bits};

  // ************************************************************
  // byte engine
  // ************************************************************
  lds_state_t state_r;
  logic [2:0] bit_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic       rd_dir_r;
  logic       ack_sda_r;
  logic [7:0] rx_byte;
  assign rx_byte = {shift_r[6:0], sda};

  // receive shifter, sampled at scl rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_r <= 8'h00;
    end else if (scl_rise) begin
      shift_r <= rx_byte;
    end
  end

  // bit counter: cleared on start, wraps from 7 to 0 at the last bit of each byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_r <= 3'h0;
    end else if (start_ev) begin
      bit_r <= 3'h0;
    end else if (scl_rise && (state_r == LDS_ADDR || state_r == LDS_PTR || state_r == LDS_WDATA)) begin
      bit_r <= bit_r + 3'h1;
    end else if (scl_fall && state_r == LDS_RDATA) begin
      bit_r <= bit_r + 3'h1;
    end
  end

  logic last_bit;
  assign last_bit = (bit_r == LDS_BIT_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r  <= LDS_IDLE;
      rd_dir_r <= 1'b0;
    end else if (start_ev) begin
      state_r <= LDS_ADDR;  // repeated start lands here too
    end else if (stop_ev) begin
      state_r <= LDS_IDLE;
    end else begin
      case (state_r)
        LDS_IDLE, LDS_IGNORE: state_r <= state_r;
        LDS_ADDR: if (scl_rise && last_bit) begin
          rd_dir_r <= sda;
          state_r  <= (rx_byte[7:1] == device_bus_address_bits) ? LDS_ADDR_ACK : LDS_IGNORE;
        end
        LDS_ADDR_ACK: if (scl_fall && ack_sda_r) begin
          state_r <= (rd_dir_r == LDS_DIR_READ) ? LDS_RDATA : LDS_PTR;
        end
        LDS_PTR: if (scl_rise && last_bit) state_r <= LDS_PTR_ACK;
        LDS_PTR_ACK: if (scl_fall && ack_sda_r) state_r <= LDS_WDATA;
        LDS_WDATA: if (scl_rise && last_bit) state_r <= LDS_WDATA_ACK;
        LDS_WDATA_ACK: if (scl_fall && ack_sda_r) state_r <= LDS_WDATA;
        LDS_RDATA: if (scl_fall && last_bit) state_r <= LDS_RDATA_ACK;
        // ack is judged at the rise; the next byte opens on the fall so its msb gets a full high phase
        LDS_RDATA_ACK: if (scl_rise && sda) begin
          state_r <= LDS_IGNORE;  // nack: wait for stop
        end else if (scl_fall) begin
          state_r <= LDS_RDATA;
        end
        default: state_r <= LDS_IDLE;
      endcase
    end
  end

  // ************************************************************
  // pointer and register-space strobes
  // ************************************************************
  logic enter_wack, enter_rbyte;
  assign enter_wack  = (state_r == LDS_WDATA) && scl_rise && last_bit && !start_ev && !stop_ev;
  // fetch at the ack fall that opens each read byte; core has a clock to answer
  assign enter_rbyte = !start_ev && !stop_ev && scl_fall &&
                       (((state_r == LDS_ADDR_ACK) && ack_sda_r && rd_dir_r) ||
                        (state_r == LDS_RDATA_ACK));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_r <= LDS_PTR_RST;
    end else if (state_r == LDS_PTR && scl_rise && last_bit && !start_ev && !stop_ev) begin
      ptr_r <= rx_byte;
    end else if (state_r == LDS_WDATA_ACK && scl_fall && ack_sda_r) begin
      ptr_r <= ptr_r + 8'h01;  // advance as the ack pulse ends
    end else if (state_r == LDS_RDATA && scl_fall && last_bit) begin
      ptr_r <= ptr_r + 8'h01;  // reads step too, so sequential reads work
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req <= '0;
    end else begin
      req.wr    <= enter_wack;
      req.rd    <= enter_rbyte;
      req.wdata <= rx_byte;
      req.addr  <= ptr_r;
    end
  end

  // ************************************************************
  // data pin drive: changes only on scl low
  // ************************************************************
  logic [7:0] tx_r;
  logic       rd_pend_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= req.rd;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_r <= 8'h00;
    end else if (rd_pend_r) begin
      tx_r <= rdata_i;
    end else if (state_r == LDS_RDATA && scl_fall) begin
      tx_r <= {tx_r[6:0], 1'b0};  // msb first
    end
  end

  // ack level held through the ack high phase
  // the bit counter has already wrapped when an ack state opens, so the
  // first fall in that state raises the pulse and the second one ends it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_sda_r <= 1'b0;
    end else if (start_ev || stop_ev) begin
      ack_sda_r <= 1'b0;
    end else if (scl_fall && !ack_sda_r &&
                 (state_r == LDS_ADDR_ACK || state_r == LDS_PTR_ACK || state_r == LDS_WDATA_ACK)) begin
      ack_sda_r <= 1'b1;
    end else if (scl_fall) begin
      ack_sda_r <= 1'b0;
    end
  end

  // the first read bit arrives a few clocks after the fall; scl low lasts far longer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_pin <= '0;
    end else begin
      sda_pin.o  <= 1'b0;
      // the shifter is stale until the fetched byte lands, so hold the line released meanwhile
      sda_pin.oe <= ack_sda_r || (state_r == LDS_RDATA && !tx_r[7] && !req.rd && !rd_pend_r);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence addr_done_s;
    state_r == LDS_ADDR && scl_rise && last_bit;
  endsequence

  sequence wack_end_s;
    state_r == LDS_WDATA_ACK && scl_fall && ack_sda_r;
  endsequence

  start_to_addr_a: assert property (@(posedge clk) disable iff (rst)
    start_ev |=> state_r == LDS_ADDR && bit_r == 3'h0)
    else $error("start did not open address phase");
  stop_to_idle_a: assert property (@(posedge clk) disable iff (rst)
    stop_ev |=> state_r == LDS_IDLE)
    else $error("stop did not end transfer");
  addr_mismatch_a: assert property (@(posedge clk) disable iff (rst)
    addr_done_s ##0 (rx_byte[7:1] != device_bus_address_bits && !start_ev && !stop_ev) |=> state_r == LDS_IGNORE)
    else $error("foreign address accepted");
  fixed_bits_a: assert property (@(posedge clk) disable iff (rst)
    addr_done_s ##0 (rx_byte[7:3] == 5'h1D && rx_byte[2:1] == low_bits && !start_ev && !stop_ev)
    |=> state_r == LDS_ADDR_ACK)
    else $error("own address refused");
  sel_decode_a: assert property (@(posedge clk) disable iff (rst)
    low_bits == {sel_b_r == LDS_SEL_VCC || sel_b_r == LDS_SEL_SDA,
                 sel_b_r == LDS_SEL_VCC || sel_b_r == LDS_SEL_SCL})
    else $error("select decode wrong");
  dir_capture_a: assert property (@(posedge clk) disable iff (rst)
    addr_done_s ##0 (!start_ev && !stop_ev) |=> rd_dir_r == $past(sda))
    else $error("direction bit not captured");
  ack_drive_a: assert property (@(posedge clk) disable iff (rst)
    ack_sda_r && !scl_fall && !start_ev && !stop_ev |-> ##2 sda_pin.oe)
    else $error("acknowledge not driven");
  ack_release_a: assert property (@(posedge clk) disable iff (rst)
    ack_sda_r && scl_fall |=> !ack_sda_r)
    else $error("acknowledge held past its pulse");
  ptr_load_a: assert property (@(posedge clk) disable iff (rst)
    state_r == LDS_PTR && scl_rise && last_bit && !start_ev && !stop_ev |=> ptr_r == $past(rx_byte))
    else $error("pointer byte not loaded");
  ptr_step_a: assert property (@(posedge clk) disable iff (rst)
    wack_end_s ##0 (!start_ev && !stop_ev) |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer did not advance");
  write_strobe_a: assert property (@(posedge clk) disable iff (rst)
    enter_wack |=> req.wr && req.addr == $past(ptr_r) && req.wdata == $past(rx_byte))
    else $error("write strobe wrong");
  read_fetch_a: assert property (@(posedge clk) disable iff (rst)
    enter_rbyte |=> req.rd ##1 rd_pend_r)
    else $error("read fetch missing");
  nack_end_a: assert property (@(posedge clk) disable iff (rst)
    state_r == LDS_RDATA_ACK && scl_rise && sda && !start_ev && !stop_ev |=> state_r == LDS_IGNORE)
    else $error("nack did not end read");
  release_ack_a: assert property (@(posedge clk) disable iff (rst)
    state_r == LDS_RDATA_ACK |=> !sda_pin.oe)
    else $error("line not released for master ack");
  quiet_line_a: assert property (@(posedge clk) disable iff (rst)
    state_r == LDS_IDLE || state_r == LDS_IGNORE |=> !sda_pin.oe)
    else $error("line driven while not addressed");

endmodule : lds_slave

// ### bench/lds_host_model.sv
/*
  lds_host_model: behavioural bus master for the led driver slave port.
  assumes the bench wires the open-drain line with a pull-up and calls the tasks.
*/
`timescale 1ns/10ps
module lds_host_model #(
  parameter int Q = 125
) (
  // clock
  input  wire logic clk,
  // bus
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // four quarters of 125 clocks give 400 kHz, the fastest allowed
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;  // idle line released high
  end

  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask : gap

  // start and repeated start alike
  task automatic start;
    sda_low_o <= 1'b0;
    gap(Q);
    scl_o <= 1'b1;
    gap(Q);
    sda_low_o <= 1'b1;
    gap(Q);
    scl_o <= 1'b0;
    gap(Q);
  endtask : start

  task automatic stop;
    sda_low_o <= 1'b1;
    gap(Q);
    scl_o <= 1'b1;
    gap(Q);
    sda_low_o <= 1'b0;
    gap(Q);
  endtask : stop

  // nine bits; a 1 releases the line, so the other side may pull it low
  task automatic xfer(input logic [8:0] d, output logic [8:0] q, output logic ok);
    logic a;
    ok = 1'b1;
    for (int i = 8; i >= 0; i--) begin
      sda_low_o <= ~d[i];  // msb first
      gap(Q);
      scl_o <= 1'b1;
      gap(Q);
      a = sda_i;
      gap(Q);
      q[i] = sda_i;
      if (q[i] !== a) ok = 1'b0;
      scl_o <= 1'b0;
      gap(Q);
    end
  endtask : xfer
endmodule : lds_host_model

// ### bench/test_led_driver_i2c_slave_port.sv
/*
  test_led_driver_i2c_slave_port: self-checking bench for lds_slave.
  assumes a byte-wide register core model here and the host model as master.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_led_driver_i2c_slave_port;
  import lds_pkg::*;
  logic       clk, rst, scl, sda, sda_low, ok;
  logic [1:0] sel_conn;
  logic [7:0] rdata;
  logic [7:0] mem [256];
  logic [8:0] q;
  lds_pin_t   sda_pin;
  lds_req_t   req;
  int         n_mismatch, total_checks, cycles, n_wr;

  // open-drain line with pull-up
  assign sda = ~(sda_low | (sda_pin.oe & ~sda_pin.o));

  lds_slave lds_slave_i (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_pin(sda_pin),
                         .sel_conn_i(sel_conn), .req(req), .rdata_i(rdata));
  lds_host_model lds_host_model_i (.clk(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  // ************************************************************
  // register core model
  // ************************************************************
  always @(posedge clk) begin
    if (req.wr) begin
      mem[req.addr] <= req.wdata;
      n_wr <= n_wr + 1;
    end
    if (req.rd) rdata <= mem[req.addr];
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic put(input logic [7:0] b);
    lds_host_model_i.xfer({b, 1'b1}, q, ok);
    `CHK(ok, 1'b1)
  endtask : put

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_select;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk) sel_conn <= 2'(s);
      lds_host_model_i.gap(10);
      lds_host_model_i.start();
      put({LDS_ADDR_FIXED, 2'(s), LDS_DIR_WRITE});
      `CHK(q[0], 1'b0)
      lds_host_model_i.stop();
      `CHK(sda_pin.oe, 1'b0)
    end
    lds_host_model_i.start();
    put({LDS_ADDR_FIXED, LDS_SEL_GND, LDS_DIR_WRITE});
    `CHK(q[0], 1'b1)
    lds_host_model_i.stop();
    lds_host_model_i.start();
    put({5'h1C, LDS_SEL_VCC, LDS_DIR_WRITE});
    `CHK(q[0], 1'b1)
    lds_host_model_i.stop();
  endtask : t_select

  task automatic t_write;
    @(posedge clk) sel_conn <= LDS_SEL_SDA;
    lds_host_model_i.gap(10);
    lds_host_model_i.start();
    put({LDS_ADDR_FIXED, LDS_SEL_SDA, LDS_DIR_WRITE});
    `CHK(q[0], 1'b0)
    put(8'hFF);
    `CHK(q[0], 1'b0)
    put(8'hA5);
    `CHK(q[0], 1'b0)
    put(8'h3C);
    `CHK(q[0], 1'b0)
    lds_host_model_i.stop();
    `CHK(n_wr, 2)
    `CHK(mem[8'hFF], 8'hA5)
    `CHK(mem[8'h00], 8'h3C)
  endtask : t_write

  task automatic t_read;
    lds_host_model_i.start();
    put({LDS_ADDR_FIXED, LDS_SEL_SDA, LDS_DIR_WRITE});
    `CHK(q[0], 1'b0)
    put(8'hFF);
    `CHK(q[0], 1'b0)
    lds_host_model_i.start();
    put({LDS_ADDR_FIXED, LDS_SEL_SDA, LDS_DIR_READ});
    `CHK(q[0], 1'b0)
    lds_host_model_i.xfer({8'hFF, 1'b0}, q, ok);
    `CHK(q, {8'hA5, 1'b0})
    `CHK(ok, 1'b1)
    lds_host_model_i.xfer({8'hFF, 1'b1}, q, ok);
    `CHK(q, {8'h3C, 1'b1})
    `CHK(sda_pin.o, 1'b0)
    lds_host_model_i.stop();
    `CHK(sda_pin.oe, 1'b0)
  endtask : t_read

  initial begin
    rst      = 1'b1;
    sel_conn = 2'h0;
    rdata    = 8'h00;
    n_wr     = 0;
    cycles   = 0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    lds_host_model_i.gap(5);
    t_select();
    t_write();
    t_read();
    end_of_test();
  end
endmodule : test_led_driver_i2c_slave_port
